// file: rtl/timer_pkg.sv
// Shared constants and types for the asynchronous timer register block
package timer_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [11:0] ADDR_CTRL_A = 12'h000;
	localparam logic [11:0] ADDR_CTRL_B = 12'h004;
	localparam logic [11:0] ADDR_COUNT  = 12'h008;
	localparam logic [11:0] ADDR_CMP_A  = 12'h00c;
	localparam logic [11:0] ADDR_CMP_B  = 12'h010;
	localparam logic [11:0] ADDR_STATUS = 12'h014;

	// ==========================================================
	// Holding register index, equal to its busy bit position
	localparam int NUM_HOLD  = 5;
	localparam int IDX_COUNT = 4;
	localparam int IDX_CMP_A = 3;
	localparam int IDX_CMP_B = 2;
	localparam int IDX_CTL_A = 1;
	localparam int IDX_CTL_B = 0;

	// ==========================================================
	// Field positions and reset values
	localparam int FORCE_A_BIT   = 7;
	localparam int FORCE_B_BIT   = 6;
	localparam int WAVE2_BIT     = 3;
	localparam int EXT_CLK_BIT   = 6;
	localparam int ASYNC_SEL_BIT = 5;
	localparam logic [7:0] CTRL_B_RD_MASK = 8'h0f;
	localparam logic [7:0] CTRL_A_RD_MASK = 8'hf3;
	localparam logic [7:0] RESET_BYTE     = 8'h00;
	localparam logic [7:0] COUNT_MAX      = 8'hff;
	localparam logic [31:0] RESET_WORD    = 32'h0000_0000;

	// ==========================================================
	// Prescaler taps: divide by 8, 32, 64, 128, 256, 1024
	localparam int PRESCALE_W = 10;
	localparam logic [PRESCALE_W-1:0] DIV8_MASK    = 10'h007;
	localparam logic [PRESCALE_W-1:0] DIV32_MASK   = 10'h01f;
	localparam logic [PRESCALE_W-1:0] DIV64_MASK   = 10'h03f;
	localparam logic [PRESCALE_W-1:0] DIV128_MASK  = 10'h07f;
	localparam logic [PRESCALE_W-1:0] DIV256_MASK  = 10'h0ff;
	localparam logic [PRESCALE_W-1:0] DIV1024_MASK = 10'h3ff;

	// ==========================================================
	// Enumerations
	typedef enum logic [1:0] {
		COM_OFF    = 2'h0,
		COM_TOGGLE = 2'h1,
		COM_CLEAR  = 2'h2,
		COM_SET    = 2'h3
	} com_t;

	typedef enum logic [2:0] {
		CS_STOP    = 3'h0,
		CS_DIV1    = 3'h1,
		CS_DIV8    = 3'h2,
		CS_DIV32   = 3'h3,
		CS_DIV64   = 3'h4,
		CS_DIV128  = 3'h5,
		CS_DIV256  = 3'h6,
		CS_DIV1024 = 3'h7
	} clk_sel_t;

	localparam logic [2:0] MODE_CTC       = 3'h2;
	localparam logic [2:0] MODE_PC_TOP_A  = 3'h5;
	localparam logic [2:0] MODE_FPWM_TOPA = 3'h7;

endpackage

// file: rtl/timer_prescaler.sv
// Prescaler and clock select for the timer count enable
`timescale 1ns/1ps
`default_nettype none
module timer_prescaler
	import timer_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       src_tick,
	input  wire logic [2:0] clock_select_field,
	output logic            count_tick
);

	typedef struct packed {
		logic [PRESCALE_W-1:0] pre;
	} pre_state_t;

	pre_state_t s_q;
	pre_state_t s_d;
	logic       tap;

	// ==========================================================
	// Tap selection
	always_comb begin
		s_d = s_q;
		if (src_tick) begin
			s_d.pre = s_q.pre + 10'h001;
		end
		unique case (clk_sel_t'(clock_select_field))
			CS_STOP:    tap = 1'b0;
			CS_DIV1:    tap = 1'b1;
			CS_DIV8:    tap = &(s_q.pre | ~DIV8_MASK);
			CS_DIV32:   tap = &(s_q.pre | ~DIV32_MASK);
			CS_DIV64:   tap = &(s_q.pre | ~DIV64_MASK);
			CS_DIV128:  tap = &(s_q.pre | ~DIV128_MASK);
			CS_DIV256:  tap = &(s_q.pre | ~DIV256_MASK);
			CS_DIV1024: tap = &(s_q.pre | ~DIV1024_MASK);
		endcase
		count_tick = src_tick & tap;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Checks
	AST_STOPPED: assert property (@(posedge pclk) disable iff (!presetn)
		clock_select_field == 3'h0 |-> !count_tick)
		else $error("Counter ticked while stopped");

	AST_DIV8_SPACING: assert property (@(posedge pclk) disable iff (!presetn)
		(clock_select_field == 3'h2 && count_tick) |-> s_q.pre[2:0] == 3'h7)
		else $error("Divide by 8 tick off its tap");

endmodule
`default_nettype wire

// file: rtl/timer_async_regs.sv
// Timer control, counter, compare and asynchronous status registers on APB
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module timer_async_regs
	import timer_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        timer_osc_input_pin,
	output logic             wave_out_pin_a,
	output logic             wave_out_pin_b,
	output logic             compare_match_a,
	output logic             compare_match_b,
	output logic [2:0]       wave_mode,
	output logic             crystal_osc_run,
	output logic             ext_clock_buffer_en
);

	typedef struct packed {
		logic [7:0]          ctl_a_tmp;
		logic [7:0]          ctl_a;
		logic [7:0]          ctl_b_tmp;
		logic [7:0]          ctl_b;
		logic [7:0]          cnt_tmp;
		logic [7:0]          cnt;
		logic [7:0]          cmp_a_tmp;
		logic [7:0]          cmp_a;
		logic [7:0]          cmp_b_tmp;
		logic [7:0]          cmp_b;
		logic [NUM_HOLD-1:0] busy;
		logic [NUM_HOLD-1:0] edge1;
		logic                as_sel;
		logic                ext_en;
		logic                osc_prev;
		logic                block;
		logic                wave_a;
		logic                wave_b;
		logic                match_a;
		logic                match_b;
		logic [31:0]         rdata;
	} state_t;

	state_t              s_q;
	state_t              s_d;
	logic                osc_rise;
	logic                src_tick;
	logic                cnt_tick;
	logic                wr_en;
	logic                addr_hit;
	logic [NUM_HOLD-1:0] wr_hit;
	logic [NUM_HOLD-1:0] land;
	logic [2:0]          mode_q;
	logic [2:0]          mode_new;
	logic [7:0]          top;
	logic                frc_a;
	logic                frc_b;
	logic                hit_a;
	logic                hit_b;

	function automatic logic wave_action(input logic [1:0] com, input logic cur);
		unique case (com_t'(com))
			COM_OFF:    wave_action = cur;
			COM_TOGGLE: wave_action = ~cur;
			COM_CLEAR:  wave_action = 1'b0;
			COM_SET:    wave_action = 1'b1;
		endcase
	endfunction

	// ==========================================================
	// Timer source and prescaler
	// Pin is taken as synchronous; the oscillator must run well below pclk
	assign osc_rise = timer_osc_input_pin & ~s_q.osc_prev;
	assign src_tick = s_q.as_sel ? osc_rise : 1'b1;

	timer_prescaler u_prescaler (
		.pclk               (pclk),
		.presetn            (presetn),
		.src_tick           (src_tick),
		.clock_select_field (s_q.ctl_b[2:0]),
		.count_tick         (cnt_tick)
	);

	// ==========================================================
	// APB decode
	always_comb begin
		addr_hit = 1'b1;
		wr_hit   = '0;
		unique case (paddr)
			ADDR_CTRL_A: wr_hit[IDX_CTL_A] = 1'b1;
			ADDR_CTRL_B: wr_hit[IDX_CTL_B] = 1'b1;
			ADDR_COUNT:  wr_hit[IDX_COUNT] = 1'b1;
			ADDR_CMP_A:  wr_hit[IDX_CMP_A] = 1'b1;
			ADDR_CMP_B:  wr_hit[IDX_CMP_B] = 1'b1;
			ADDR_STATUS: addr_hit = 1'b1;
			default:     addr_hit = 1'b0;
		endcase
		wr_en  = psel & penable & pwrite & addr_hit;
		wr_hit = wr_en ? wr_hit : '0;
	end

	assign pready  = penable;
	assign pslverr = psel & penable & ~addr_hit;
	assign prdata  = s_q.rdata;

	// ==========================================================
	// Next state
	always_comb begin
		s_d          = s_q;
		s_d.osc_prev = timer_osc_input_pin;

		// Read data is captured in the setup cycle so prdata is a flop
		if (psel && !penable && !pwrite) begin
			unique case (paddr)
				ADDR_CTRL_A: s_d.rdata = {24'h0, s_q.ctl_a_tmp & CTRL_A_RD_MASK};
				ADDR_CTRL_B: s_d.rdata = {24'h0, s_q.ctl_b_tmp & CTRL_B_RD_MASK};
				ADDR_COUNT:  s_d.rdata = {24'h0, s_q.cnt};
				ADDR_CMP_A:  s_d.rdata = {24'h0, s_q.cmp_a_tmp};
				ADDR_CMP_B:  s_d.rdata = {24'h0, s_q.cmp_b_tmp};
				ADDR_STATUS: s_d.rdata = {24'h0, 1'b0, s_q.ext_en, s_q.as_sel, s_q.busy};
				default:     s_d.rdata = RESET_WORD;
			endcase
		end

		// Holding register writes
		if (wr_hit[IDX_CTL_A]) s_d.ctl_a_tmp = pwdata[7:0];
		if (wr_hit[IDX_CTL_B]) s_d.ctl_b_tmp = pwdata[7:0];
		if (wr_hit[IDX_COUNT]) s_d.cnt_tmp = pwdata[7:0];
		if (wr_hit[IDX_CMP_A]) s_d.cmp_a_tmp = pwdata[7:0];
		if (wr_hit[IDX_CMP_B]) s_d.cmp_b_tmp = pwdata[7:0];
		// A change of clock source leaves register contents as they fall
		if (wr_en && paddr == ADDR_STATUS) begin
			s_d.ext_en = pwdata[EXT_CLK_BIT];
			s_d.as_sel = pwdata[ASYNC_SEL_BIT];
		end

		// Busy tracking: a rewrite restarts the two-edge wait
		for (int i = 0; i < NUM_HOLD; i++) begin
			land[i] = 1'b0;
			if (!s_q.as_sel) begin
				land[i]      = wr_hit[i] | s_q.busy[i];
				s_d.busy[i]  = 1'b0;
				s_d.edge1[i] = 1'b0;
			end else if (wr_hit[i]) begin
				s_d.busy[i]  = 1'b1;
				s_d.edge1[i] = 1'b0;
			end else if (s_q.busy[i] && osc_rise) begin
				if (s_q.edge1[i]) begin
					land[i]     = 1'b1;
					s_d.busy[i] = 1'b0;
				end
				s_d.edge1[i] = ~s_q.edge1[i];
			end
		end

		// Landing into destinations
		if (land[IDX_CTL_A]) s_d.ctl_a = s_d.ctl_a_tmp & CTRL_A_RD_MASK;
		if (land[IDX_CTL_B]) begin
			s_d.ctl_b = s_d.ctl_b_tmp & CTRL_B_RD_MASK;
			s_d.ctl_b_tmp[FORCE_A_BIT] = 1'b0;
			s_d.ctl_b_tmp[FORCE_B_BIT] = 1'b0;
		end
		if (land[IDX_CMP_A]) s_d.cmp_a = s_d.cmp_a_tmp;
		if (land[IDX_CMP_B]) s_d.cmp_b = s_d.cmp_b_tmp;

		// Force strobes fire as control B lands, under the new mode
		mode_new = {s_d.ctl_b[WAVE2_BIT], s_d.ctl_a[1:0]};
		frc_a = land[IDX_CTL_B] & (wr_hit[IDX_CTL_B] ? pwdata[FORCE_A_BIT]
			: s_q.ctl_b_tmp[FORCE_A_BIT]) & ~mode_new[0];
		frc_b = land[IDX_CTL_B] & (wr_hit[IDX_CTL_B] ? pwdata[FORCE_B_BIT]
			: s_q.ctl_b_tmp[FORCE_B_BIT]) & ~mode_new[0];

		// Counter and compare
		mode_q = {s_q.ctl_b[WAVE2_BIT], s_q.ctl_a[1:0]};
		top = (mode_q == MODE_CTC || mode_q == MODE_PC_TOP_A || mode_q == MODE_FPWM_TOPA)
			? s_q.cmp_a : COUNT_MAX;
		hit_a = cnt_tick & ~s_q.block & (s_q.cnt == s_q.cmp_a);
		hit_b = cnt_tick & ~s_q.block & (s_q.cnt == s_q.cmp_b);
		s_d.match_a = hit_a;
		s_d.match_b = hit_b;
		if (land[IDX_COUNT]) begin
			s_d.cnt   = s_d.cnt_tmp;
			s_d.block = 1'b1;
		end else if (cnt_tick) begin
			s_d.block = 1'b0;
			// Reaching top clears the counter, even while its match is blocked; forces never reach here
			s_d.cnt = (s_q.cnt == top) ? RESET_BYTE : s_q.cnt + 8'h01;
		end

		// Waveform pins: PWM shaping belongs to the waveform unit elsewhere
		if (!mode_q[0] && (hit_a || frc_a)) begin
			s_d.wave_a = wave_action(s_q.ctl_a[7:6], s_q.wave_a);
		end
		if (!mode_q[0] && (hit_b || frc_b)) begin
			s_d.wave_b = wave_action(s_q.ctl_a[5:4], s_q.wave_b);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Outputs
	assign wave_out_pin_a      = s_q.wave_a;
	assign wave_out_pin_b      = s_q.wave_b;
	assign compare_match_a     = s_q.match_a;
	assign compare_match_b     = s_q.match_b;
	assign wave_mode           = {s_q.ctl_b[WAVE2_BIT], s_q.ctl_a[1:0]};
	assign crystal_osc_run     = s_q.as_sel & ~s_q.ext_en;
	assign ext_clock_buffer_en = s_q.as_sel & s_q.ext_en;

	// ==========================================================
	// Checks
	sequence s_count_write_async;
		s_q.as_sel && wr_hit[IDX_COUNT];
	endsequence

	sequence s_second_edge(int idx);
		s_q.as_sel && s_q.busy[idx] && s_q.edge1[idx] && osc_rise && !wr_hit[idx];
	endsequence

	AST_PWM_NO_FORCE: assert property (@(posedge pclk) disable iff (!presetn)
		(wave_mode[0] && $past(wave_mode[0])) |-> $stable(wave_out_pin_a))
		else $error("Pin A moved in a PWM mode");

	AST_FORCE_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
		(frc_a && !mode_q[0] && s_q.ctl_a[7:6] == 2'h1) |=> wave_out_pin_a != $past(wave_out_pin_a))
		else $error("Forced toggle did not toggle pin A");

	AST_FORCE_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
		(frc_b && !cnt_tick) |=> !compare_match_b)
		else $error("Force raised a match pulse");

	AST_CTRL_B_READ: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && !pwrite && paddr == ADDR_CTRL_B) |-> prdata[7:4] == 4'h0)
		else $error("Control B upper bits read nonzero");

	AST_BLOCK_MATCH: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.block && cnt_tick) |=> !compare_match_a && !compare_match_b)
		else $error("Match not blocked after counter write");

	AST_COUNT_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
		s_count_write_async |=> s_q.busy[IDX_COUNT] && s_q.cnt_tmp == $past(pwdata[7:0]))
		else $error("Counter busy not set on async write");

	AST_CMPA_LAND: assert property (@(posedge pclk) disable iff (!presetn)
		s_second_edge(IDX_CMP_A) |=> !s_q.busy[IDX_CMP_A] && s_q.cmp_a == s_q.cmp_a_tmp)
		else $error("Compare A did not land on second edge");

	AST_SYNC_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
		!$past(s_q.as_sel) |-> s_q.busy == '0)
		else $error("Busy set in synchronous mode");

	sequence s_read_setup(logic [11:0] addr);
		psel && !penable && !pwrite && paddr == addr;
	endsequence

	sequence s_first_edge(int idx);
		s_q.as_sel && s_q.busy[idx] && !s_q.edge1[idx] && osc_rise && !wr_hit[idx];
	endsequence

	AST_STATUS_READ: assert property (@(posedge pclk) disable iff (!presetn)
		s_read_setup(ADDR_STATUS) |=> prdata[31:7] == 25'h0)
		else $error("Status read shows a bit above the select bits");

	AST_COUNT_LIVE: assert property (@(posedge pclk) disable iff (!presetn)
		s_read_setup(ADDR_COUNT) |=> prdata[7:0] == $past(s_q.cnt))
		else $error("Counter read did not show the live count");

	AST_CMPA_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		s_read_setup(ADDR_CMP_A) |=> prdata[7:0] == $past(s_q.cmp_a_tmp))
		else $error("Compare A read did not show the holding value");

	AST_CMPA_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.as_sel && wr_hit[IDX_CMP_A]) |=> s_q.busy[IDX_CMP_A])
		else $error("Compare A busy not set on async write");

	AST_CMPB_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.as_sel && wr_hit[IDX_CMP_B]) |=> s_q.busy[IDX_CMP_B])
		else $error("Compare B busy not set on async write");

	AST_CTLA_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.as_sel && wr_hit[IDX_CTL_A]) |=> s_q.busy[IDX_CTL_A])
		else $error("Control A busy not set on async write");

	AST_CTLB_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.as_sel && wr_hit[IDX_CTL_B]) |=> s_q.busy[IDX_CTL_B])
		else $error("Control B busy not set on async write");

	AST_SYNC_DIRECT: assert property (@(posedge pclk) disable iff (!presetn)
		(!s_q.as_sel && wr_hit[IDX_CMP_B]) |=> s_q.cmp_b == $past(pwdata[7:0]))
		else $error("Synchronous compare B write did not land at once");

	AST_FIRST_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
		s_first_edge(IDX_COUNT) |=> s_q.busy[IDX_COUNT] && s_q.edge1[IDX_COUNT])
		else $error("Counter landed after a single oscillator edge");

	AST_COUNT_LAND: assert property (@(posedge pclk) disable iff (!presetn)
		s_second_edge(IDX_COUNT) |=> !s_q.busy[IDX_COUNT] && s_q.cnt == s_q.cnt_tmp)
		else $error("Counter did not land on second edge");

	AST_EXT_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
		!s_q.as_sel |-> !ext_clock_buffer_en && !crystal_osc_run)
		else $error("Oscillator controls active without async select");

	AST_STOP_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.ctl_b[2:0] == 3'h0 && !land[IDX_COUNT])
		|=> s_q.cnt == $past(s_q.cnt) && !compare_match_a && !compare_match_b)
		else $error("Stopped counter moved or matched");

	AST_MATCH_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
		(cnt_tick && !s_q.block && s_q.cnt == s_q.cmp_a) |=> compare_match_a)
		else $error("Compare A match gave no pulse");

	AST_FORCE_NO_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
		(frc_a && !cnt_tick && !land[IDX_COUNT]) |=> s_q.cnt == $past(s_q.cnt))
		else $error("Force strobe changed the counter");

	AST_FORCE_TOGGLE_B: assert property (@(posedge pclk) disable iff (!presetn)
		(frc_b && !mode_q[0] && s_q.ctl_a[5:4] == 2'h1) |=> wave_out_pin_b != $past(wave_out_pin_b))
		else $error("Forced toggle did not toggle pin B");

endmodule
`default_nettype wire

// file: tb/test_async_timer_ctrl_compare.sv
// Self-checking bench for the asynchronous timer register block
`timescale 1ns/1ps
`default_nettype none
module test_async_timer_ctrl_compare;
	import timer_pkg::*;
	// ==========================================================
	// Signals
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        osc_pin;
	logic        pin_a;
	logic        pin_b;
	logic        match_a;
	logic        match_b;
	logic [2:0]  wave_mode;
	logic        xtal_run;
	logic        buf_en;
	int          errors;
	int          checked;
	int          hits_a;
	int          hits_b;

	timer_async_regs dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer_osc_input_pin(osc_pin), .wave_out_pin_a(pin_a), .wave_out_pin_b(pin_b),
		.compare_match_a(match_a), .compare_match_b(match_b), .wave_mode(wave_mode),
		.crystal_osc_run(xtal_run), .ext_clock_buffer_en(buf_en)
	);

	// ==========================================================
	// Clock and match pulse counters
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		if (match_a === 1'b1) hits_a++;
		if (match_b === 1'b1) hits_b++;
	end

	// ==========================================================
	// Shared tasks
	task wrap_up();
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Starts at the next edge; the leading wait keeps back-to-back calls off one time step
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			errors++;
			wrap_up();
		end
	endtask

	task wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task rd(input string what, input logic [11:0] a, input logic [7:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 8'h00, r, e);
		chk(what, {24'h00_0000, exp}, r);
	endtask

	// Oscillator only moves inside these bursts
	task osc(input int n);
		repeat (n) begin
			osc_pin <= 1'b1;
			repeat (2) @(posedge pclk);
			osc_pin <= 1'b0;
			repeat (2) @(posedge pclk);
		end
	endtask

	// ==========================================================
	// Scenarios
	task sc_reset_and_bus();
		logic [31:0] r;
		logic        e;
		rd("status reset", ADDR_STATUS, 8'h00);
		rd("ctrl_b reset", ADDR_CTRL_B, 8'h00);
		apb(1'b0, 12'h018, 8'h00, r, e);
		chk("unmapped err", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, r);
	endtask

	task sc_force();
		logic pa;
		logic pb;
		wr(ADDR_CTRL_A, 8'h52);
		wr(ADDR_COUNT, 8'h33);
		wr(ADDR_CMP_A, 8'h33);
		rd("count rw", ADDR_COUNT, 8'h33);
		pa = pin_a;
		pb = pin_b;
		hits_a = 0;
		hits_b = 0;
		wr(ADDR_CTRL_B, 8'hc0);
		repeat (3) @(posedge pclk);
		chk("forced pin a", {31'h0, ~pa}, {31'h0, pin_a});
		chk("forced pin b", {31'h0, ~pb}, {31'h0, pin_b});
		chk("force match pulses", 32'h0, hits_a + hits_b);
		rd("ctc not cleared", ADDR_COUNT, 8'h33);
		rd("force bits read", ADDR_CTRL_B, 8'h00);
		wr(ADDR_CTRL_B, 8'hf8);
		rd("reserved bits read", ADDR_CTRL_B, 8'h08);
		wr(ADDR_CTRL_B, 8'h00);
		wr(ADDR_CTRL_A, 8'h53);
		wr(ADDR_CTRL_B, 8'h00);
		repeat (3) @(posedge pclk);
		chk("pwm mode", 32'h3, {29'h0, wave_mode});
	endtask

	task sc_match();
		logic pa;
		wr(ADDR_CTRL_A, 8'h50);
		wr(ADDR_CMP_A, 8'h20);
		wr(ADDR_CMP_B, 8'h30);
		wr(ADDR_COUNT, 8'h20);
		pa = pin_a;
		hits_a = 0;
		hits_b = 0;
		wr(ADDR_CTRL_B, 8'h01);
		repeat (10) @(posedge pclk);
		chk("blocked match", 32'h0, hits_a);
		repeat (250) @(posedge pclk);
		chk("match a once", 32'h1, hits_a);
		chk("match b once", 32'h1, hits_b);
		chk("match pin a", {31'h0, ~pa}, {31'h0, pin_a});
		wr(ADDR_CTRL_B, 8'h00);
	endtask

	task sc_prescale();
		int div[8];
		logic [31:0] r0;
		logic [31:0] r1;
		logic        e;
		int w;
		div = '{0, 1, 8, 32, 64, 128, 256, 1024};
		for (int c = 0; c < 8; c++) begin
			w = (div[c] < 8) ? 16 : 2 * div[c];
			wr(ADDR_CTRL_B, c[7:0]);
			apb(1'b0, ADDR_COUNT, 8'h00, r0, e);
			repeat (w - 3) @(posedge pclk);
			apb(1'b0, ADDR_COUNT, 8'h00, r1, e);
			chk("prescale step", (div[c] == 0) ? 32'h0 : (w / div[c]), {24'h0, r1[7:0] - r0[7:0]});
		end
		wr(ADDR_CTRL_B, 8'h00);
	endtask

	task sc_async();
		logic pa;
		wr(ADDR_COUNT, 8'h11);
		rd("sync busy clear", ADDR_STATUS, 8'h00);
		wr(ADDR_STATUS, 8'h40);
		repeat (2) @(posedge pclk);
		chk("ext buffer idle", 32'h0, {31'h0, buf_en});
		wr(ADDR_STATUS, 8'hff);
		rd("status access", ADDR_STATUS, 8'h60);
		chk("ext buffer", 32'h1, {31'h0, buf_en});
		chk("crystal off", 32'h0, {31'h0, xtal_run});
		// Live mode is still non-PWM here, but the force lands together with the PWM mode of control A and is ignored
		wr(ADDR_COUNT, 8'h40);
		wr(ADDR_CMP_A, 8'h77);
		wr(ADDR_CMP_B, 8'h66);
		wr(ADDR_CTRL_A, 8'h53);
		pa = pin_a;
		wr(ADDR_CTRL_B, 8'hc0);
		rd("all busy", ADDR_STATUS, 8'h7f);
		rd("count live", ADDR_COUNT, 8'h11);
		rd("cmp a holding", ADDR_CMP_A, 8'h77);
		osc(1);
		rd("busy after one edge", ADDR_STATUS, 8'h7f);
		osc(1);
		repeat (3) @(posedge pclk);
		rd("busy cleared", ADDR_STATUS, 8'h60);
		rd("count landed", ADDR_COUNT, 8'h40);
		chk("pwm force ignored", {31'h0, pa}, {31'h0, pin_a});
		wr(ADDR_STATUS, 8'h20);
		repeat (2) @(posedge pclk);
		chk("crystal on", 32'h1, {31'h0, xtal_run});
		chk("ext buffer off", 32'h0, {31'h0, buf_en});
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		errors = 0;
		checked = 0;
		hits_a = 0;
		hits_b = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		osc_pin = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		sc_reset_and_bus();
		sc_force();
		sc_match();
		sc_prescale();
		sc_async();
		wrap_up();
	end
endmodule
`default_nettype wire
